/* File: verilog/smpwm_top.sv */
// stepper pwm scheduler: registers, ramp counter, scheduler, units
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
module smpwm_top
    import smpwm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // fixed options and shared-port pwm source
    input wire logic hw_clk_sel,
    input wire logic hw_unit_e_sel,
    input wire logic [1:0] ext_pwm_plus,
    input wire logic [1:0] ext_pwm_minus,
    // h-bridge drive, index 2*unit+coil
    output logic [9:0] bridge_plus_output,
    output logic [9:0] bridge_minus_output
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [5:0] pin_s1_q;
    logic [5:0] pin_s2_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic motor_module_enable_q;
    logic [2:0] sel_q;
    logic [1:0] quad_q;
    logic [7:0] cos_buf_q;
    logic [7:0] sin_buf_q;
    logic busy_q;
    logic busy_d;
    logic [3:0] div_q;
    logic [7:0] pwm_ramp_counter_q;
    logic [9:0] plus_q;
    logic [9:0] minus_q;
    logic [9:0] plus_d;
    logic [9:0] minus_d;
    logic [12:0] busy_cyc_q;
    logic hit_uqb;
    logic hit_cos;
    logic hit_sin;
    logic hit_ctl;
    logic hit_stat;

    wire clk_sel_s = pin_s2_q[5];
    wire unit_e_s = pin_s2_q[4];
    wire [1:0] ext_plus_s = pin_s2_q[3:2];
    wire [1:0] ext_minus_s = pin_s2_q[1:0];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
        end else begin
            pin_s1_q <= {hw_clk_sel, hw_unit_e_sel,
                         ext_pwm_plus, ext_pwm_minus};
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then accept
    wire req = avs_read | avs_write;
    wire first = req & wait_q;
    wire acc = req & ~wait_q;
    wire wr_acc = acc & avs_write & avs_byteenable[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~first;
        end
    end

    // address decode
    always_comb begin
        hit_uqb = 1'b0;
        hit_cos = 1'b0;
        hit_sin = 1'b0;
        hit_ctl = 1'b0;
        hit_stat = 1'b0;
        if (avs_address == OFS_UQB) begin
            hit_uqb = 1'b1;
        end else if (avs_address == OFS_COS) begin
            hit_cos = 1'b1;
        end else if (avs_address == OFS_SIN) begin
            hit_sin = 1'b1;
        end else if (avs_address == OFS_CTL) begin
            hit_ctl = 1'b1;
        end else if (avs_address == OFS_STAT) begin
            hit_stat = 1'b1;
        end
    end

    // write strobes; buffers only take writes while enabled
    wire en = motor_module_enable_q;
    wire wr_ctl = wr_acc & hit_ctl;
    wire wr_uqb = wr_acc & hit_uqb & en;
    wire wr_cos = wr_acc & hit_cos & en;
    wire wr_sin = wr_acc & hit_sin & en;

    // read data, unmapped and write-only read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_sin) begin
            rdata_d[BUSY_BIT] = busy_q;
        end else if (hit_ctl) begin
            rdata_d[CTL_EN_BIT] = motor_module_enable_q;
        end else if (hit_stat) begin
            rdata_d[7:0] = pwm_ramp_counter_q;
            rdata_d[STAT_BUSY_BIT] = busy_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (first & avs_read) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // module enable
    always_ff @(posedge clk) begin
        if (rst) begin
            motor_module_enable_q <= 1'b0;
        end else if (wr_ctl) begin
            motor_module_enable_q <= avs_writedata[CTL_EN_BIT];
        end
    end

    wire kill = rst | ~en;

    ////////////////////////////////////////////////////////////////////////
    // value buffers
    always_ff @(posedge clk) begin
        if (kill) begin
            sel_q <= SEL_RST;
            quad_q <= QUAD_RST;
            cos_buf_q <= BUF_RST;
            sin_buf_q <= BUF_RST;
        end else begin
            if (wr_uqb) begin
                sel_q <= avs_writedata[UQB_SEL_LSB +: 3];
                quad_q <= avs_writedata[UQB_QUAD_LSB +: 2];
            end
            if (wr_cos) begin
                cos_buf_q <= avs_writedata[7:0];
            end
            if (wr_sin) begin
                sin_buf_q <= avs_writedata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // motor clock tick from option-selected divider
    wire [3:0] div_lim = clk_sel_s ? DIV_SLOW_M1 : DIV_FAST_M1;
    wire tick = en & (div_q == div_lim);

    always_ff @(posedge clk) begin
        if (kill || tick) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // ramp counts from enable, clears to zero on disable
    always_ff @(posedge clk) begin
        if (kill) begin
            pwm_ramp_counter_q <= RAMP_ZERO;
        end else if (tick) begin
            pwm_ramp_counter_q <= pwm_ramp_counter_q + 8'h01;
        end
    end

    wire wrap = tick & (pwm_ramp_counter_q == RAMP_TOP);

    ////////////////////////////////////////////////////////////////////////
    // scheduler
    // transfer at wrap, busy drops with it
    wire xfer = wrap & busy_q;

    // sine write launches; set wins over clear
    always_comb begin
        busy_d = busy_q;
        if (wr_sin) begin
            busy_d = 1'b1;
        end else if (xfer) begin
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (kill) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control units, each with its own delay
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        logic c1p;
        logic c1m;
        logic c2p;
        logic c2m;
        // codes above 100 load no unit
        wire load = xfer & (sel_q == 3'(u));

        smpwm_unit #(
            .DLY(u + 1)
        ) u_unit (
            .clk(clk),
            .rst(rst),
            .clr(~en),
            .tick(tick),
            .ramp(pwm_ramp_counter_q),
            .load(load),
            .ld_sin(sin_buf_q),
            .ld_cos(cos_buf_q),
            .ld_quad(quad_q),
            .coil1_p(c1p),
            .coil1_m(c1m),
            .coil2_p(c2p),
            .coil2_m(c2m)
        );

        if (u == NUM_UNITS - 1) begin : g_shared
            // shared ports: unit e or external pwm
            assign plus_d[2*u +: 2] = unit_e_s ? {c2p, c1p} : ext_plus_s;
            assign minus_d[2*u +: 2] = unit_e_s ? {c2m, c1m} : ext_minus_s;
        end else begin : g_own
            assign plus_d[2*u +: 2] = {c2p, c1p};
            assign minus_d[2*u +: 2] = {c2m, c1m};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            plus_q <= 10'h000;
            minus_q <= 10'h000;
        end else begin
            plus_q <= plus_d;
            minus_q <= minus_d;
        end
    end

    assign bridge_plus_output = plus_q;
    assign bridge_minus_output = minus_q;
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clk) begin
        if (kill || !busy_q) begin
            busy_cyc_q <= 13'h0000;
        end else if (busy_cyc_q != 13'h1FFF) begin
            busy_cyc_q <= busy_cyc_q + 13'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence sin_write_s;
        en && wr_sin;
    endsequence

    sequence xfer_done_s;
        busy_q ##1 !busy_q && en;
    endsequence

    ramp_wrap_a: assert property (
        wrap && en |=> pwm_ramp_counter_q == RAMP_ZERO)
        else $error("ramp did not wrap to zero");

    ramp_halt_a: assert property (
        !en |=> pwm_ramp_counter_q == RAMP_ZERO && !busy_q)
        else $error("ramp or busy survives disable");

    outs_off_a: assert property (
        !en ##1 !en ##1 !en |->
            plus_q[7:0] == 8'h00 && minus_q[7:0] == 8'h00)
        else $error("bridge output high while disabled");

    busy_set_a: assert property (
        sin_write_s |=> busy_q)
        else $error("sine write did not set busy");

    busy_bound_a: assert property (
        busy_cyc_q <= BUSY_MAX_CYC)
        else $error("transfer took longer than one period");

    xfer_zero_a: assert property (
        xfer_done_s |-> pwm_ramp_counter_q == RAMP_ZERO)
        else $error("busy cleared away from ramp zero");

    busy_read_a: assert property (
        first && avs_read && hit_sin |=>
            avs_readdata[BUSY_BIT] == $past(busy_q))
        else $error("sine read does not show busy");

    bus_wait_a: assert property (
        first |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not one cycle low");

endmodule

/* File: verilog/smpwm_pkg.sv */
// constants shared by the stepper pwm scheduler files
package smpwm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_UNITS = 5;
    localparam int RAMP_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [4:0] OFS_UQB = 5'h00;
    localparam logic [4:0] OFS_COS = 5'h04;
    localparam logic [4:0] OFS_SIN = 5'h08;
    localparam logic [4:0] OFS_CTL = 5'h0C;
    localparam logic [4:0] OFS_STAT = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int UQB_QUAD_LSB = 0;
    localparam int UQB_SEL_LSB = 3;
    localparam int BUSY_BIT = 0;
    localparam int CTL_EN_BIT = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [1:0] QUAD_RST = 2'h0;
    localparam logic [7:0] RAMP_ZERO = 8'h00;
    localparam logic [7:0] RAMP_TOP = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // timing: 20 MHz system clock, motor clock by divider
    localparam int CLK_HZ = 20_000_000;
    localparam int MOTOR_FAST_HZ = 4_000_000;
    localparam int MOTOR_SLOW_HZ = 2_000_000;
    localparam int DIV_FAST = CLK_HZ / MOTOR_FAST_HZ;
    localparam int DIV_SLOW = CLK_HZ / MOTOR_SLOW_HZ;
    localparam logic [3:0] DIV_FAST_M1 = 4'(DIV_FAST - 1);
    localparam logic [3:0] DIV_SLOW_M1 = 4'(DIV_SLOW - 1);
    localparam int PERIOD_TICKS = 256;
    localparam logic [12:0] BUSY_MAX_CYC =
        13'(PERIOD_TICKS * DIV_SLOW + 2);

endpackage

/* File: verilog/smpwm_unit.sv */
// one motor control unit: compare, delay and quadrant routing
`timescale 1ns/1ns
module smpwm_unit
    import smpwm_pkg::*;
#(
    parameter int DLY = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // module control
    input wire logic clr,
    input wire logic tick,
    input wire logic [7:0] ramp,
    // new values from the scheduler
    input wire logic load,
    input wire logic [7:0] ld_sin,
    input wire logic [7:0] ld_cos,
    input wire logic [1:0] ld_quad,
    // bridge drive, coil 1 and coil 2
    output logic coil1_p,
    output logic coil1_m,
    output logic coil2_p,
    output logic coil2_m
);

    logic [7:0] sin_q;
    logic [7:0] cos_q;
    logic [1:0] quad_q;
    logic sin_ff_q;
    logic cos_ff_q;
    logic [1:0] dly_q [DLY];
    wire kill = rst | clr;
    wire sin_ff_d;
    wire cos_ff_d;
    wire sin_dly;
    wire cos_dly;

    ////////////////////////////////////////////////////////////////////////
    // compare registers
    always_ff @(posedge clk) begin
        if (kill) begin
            sin_q <= BUF_RST;
            cos_q <= BUF_RST;
            quad_q <= QUAD_RST;
        end else if (load) begin
            sin_q <= ld_sin;
            cos_q <= ld_cos;
            quad_q <= ld_quad;
        end
    end

    // match wins at zero, so 00h stays low
    assign sin_ff_d = (ramp == sin_q) ? 1'b0 :
                      (ramp == RAMP_ZERO) ? 1'b1 : sin_ff_q;
    assign cos_ff_d = (ramp == cos_q) ? 1'b0 :
                      (ramp == RAMP_ZERO) ? 1'b1 : cos_ff_q;

    always_ff @(posedge clk) begin
        if (kill) begin
            sin_ff_q <= 1'b0;
            cos_ff_q <= 1'b0;
        end else if (tick) begin
            sin_ff_q <= sin_ff_d;
            cos_ff_q <= cos_ff_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fixed delay in motor ticks
    for (genvar g = 0; g < DLY; g++) begin : g_dly
        wire [1:0] stage_in;
        // first stage reads the flops, later stages the one before
        if (g == 0) begin : g_head
            assign stage_in = {sin_ff_q, cos_ff_q};
        end else begin : g_link
            assign stage_in = dly_q[g - 1];
        end
        always_ff @(posedge clk) begin
            if (kill) begin
                dly_q[g] <= 2'b00;
            end else if (tick) begin
                dly_q[g] <= stage_in;
            end
        end
    end

    assign sin_dly = dly_q[DLY - 1][1];
    assign cos_dly = dly_q[DLY - 1][0];

    assign coil1_p = ~quad_q[1] & sin_dly;
    assign coil1_m = quad_q[1] & sin_dly;
    assign coil2_p = ~(quad_q[1] ^ quad_q[0]) & cos_dly;
    assign coil2_m = (quad_q[1] ^ quad_q[0]) & cos_dly;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst | clr);

    cmp_clear_a: assert property (
        tick && ramp == sin_q |=> !sin_ff_q)
        else $error("sine flop not cleared by match");

    zero_set_a: assert property (
        tick && ramp == RAMP_ZERO && sin_q != RAMP_ZERO |=> sin_ff_q)
        else $error("sine flop not set at zero");

    quad_route_a: assert property (
        quad_q == 2'b01 |-> !coil1_m && !coil2_p)
        else $error("quadrant 01 drives an unused leg");

endmodule

/* File: test/smpwm_coil_meter.sv */
// h-bridge side model: measures high time of every bridge leg
`timescale 1ns/1ns
module smpwm_coil_meter
    import smpwm_pkg::*;
#(
    parameter int WIN = 1280
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // measurement control
    input wire logic start,
    output logic done,
    // bridge legs seen by the coils
    input wire logic [9:0] plus,
    input wire logic [9:0] minus,
    // high cycles counted per leg
    output logic [11:0] plus_cnt [10],
    output logic [11:0] minus_cnt [10]
);
    logic [11:0] win_q;

    ////////////////////////////////////////////////////////////////////////
    // one period window
    always_ff @(posedge clk) begin
        if (rst || start) begin
            win_q <= rst ? 12'h0 : 12'(WIN);
            done <= rst;
            for (int i = 0; i < 10; i++) begin
                plus_cnt[i] <= 12'h0;
                minus_cnt[i] <= 12'h0;
            end
        end else if (win_q != 12'h0) begin
            win_q <= win_q - 12'h1;
            done <= (win_q == 12'h1);
            for (int i = 0; i < 10; i++) begin
                plus_cnt[i] <= plus_cnt[i] + 12'(plus[i]);
                minus_cnt[i] <= minus_cnt[i] + 12'(minus[i]);
            end
        end
    end
endmodule

/* File: test/smpwm_tb.sv */
// self-checking bench for the stepper pwm scheduler
`timescale 1ns/1ns
module testbench
    import smpwm_pkg::*;
;
    typedef struct packed {
        logic [2:0] sel;
        logic [1:0] quad;
        logic [7:0] sin_v;
        logic [7:0] cos_v;
        logic [31:0] exp;
    } smpwm_row_t;

    localparam smpwm_row_t ROWS [7] = '{
        '{3'h0, 2'h0, 8'h80, 8'h40, 32'h8000_4000},
        '{3'h1, 2'h1, 8'hFF, 8'h01, 32'hFF00_0001},
        '{3'h2, 2'h2, 8'h01, 8'hFE, 32'h0001_00FE},
        '{3'h3, 2'h3, 8'h00, 8'h80, 32'h0000_8000},
        '{3'h4, 2'h0, 8'h10, 8'hFF, 32'h1000_FF00},
        '{3'h0, 2'h2, 8'hC0, 8'h20, 32'h00C0_0020},
        '{3'h2, 2'h3, 8'h55, 8'hAA, 32'h0055_AA00}};

    logic clk, rst, avs_read, avs_write, avs_waitrequest;
    logic hw_clk_sel, hw_unit_e_sel, start, done;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, s1;
    logic [3:0] avs_byteenable;
    logic [1:0] ext_pwm_plus, ext_pwm_minus;
    logic [9:0] bridge_plus_output, bridge_minus_output;
    logic [11:0] plus_cnt [10];
    logic [11:0] minus_cnt [10];
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0, k, u;

    smpwm_top DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .hw_clk_sel(hw_clk_sel), .hw_unit_e_sel(hw_unit_e_sel),
        .ext_pwm_plus(ext_pwm_plus), .ext_pwm_minus(ext_pwm_minus),
        .bridge_plus_output(bridge_plus_output),
        .bridge_minus_output(bridge_minus_output));

    smpwm_coil_meter #(.WIN(PERIOD_TICKS * DIV_FAST)) meter (.clk(clk),
        .rst(rst), .start(start), .done(done), .plus(bridge_plus_output),
        .minus(bridge_minus_output), .plus_cnt(plus_cnt),
        .minus_cnt(minus_cnt));

    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors=%0d n_checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic timeout(input string nm);
        errors++;
        $display("mismatch %s expected done seen timeout", nm);
        results();
    endtask

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 20) timeout("waitrequest");
    endtask

    task automatic quiet(input int n, input string nm);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if ((bridge_plus_output | bridge_minus_output) !== 10'h0)
                bad = 1'b1;
        end
        chk(nm, 32'h0, 32'(bad));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {avs_read, avs_write, start} = 3'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        hw_clk_sel = 1'b0;
        hw_unit_e_sel = 1'b1;
        ext_pwm_plus = 2'h0;
        ext_pwm_minus = 2'h0;
        repeat (10) @(posedge clk);
        chk("waitrequest", 32'h1, 32'(avs_waitrequest));
        quiet(2, "bridge in reset");
        rst <= 1'b0;
        bus(0, OFS_STAT, 0);
        chk("status after reset", 32'h0, q);
        bus(1, OFS_SIN, 32'h44);
        bus(0, OFS_SIN, 0);
        chk("busy while off", 32'h0, q);
        bus(1, 5'h14, 32'h5A);
        bus(0, 5'h14, 0);
        chk("unmapped read", 32'h0, q);
        bus(1, OFS_CTL, 32'h1);
        bus(0, OFS_STAT, 0);
        s1 = q;
        // reads 100 cycles apart see a whole number of ticks
        repeat (97) @(posedge clk);
        bus(0, OFS_STAT, 0);
        chk("ramp runs", 32'(100 / DIV_FAST),
            32'(8'(q[7:0] - s1[7:0])));
        quiet(300, "outputs before load");
        hw_unit_e_sel <= 1'b0;
        ext_pwm_plus <= 2'h1;
        ext_pwm_minus <= 2'h2;
        repeat (8) @(posedge clk);
        chk("shared plus", 32'h1, 32'(bridge_plus_output[9:8]));
        chk("shared minus", 32'h2, 32'(bridge_minus_output[9:8]));
        hw_unit_e_sel <= 1'b1;
        ext_pwm_plus <= 2'h0;
        ext_pwm_minus <= 2'h0;
        foreach (ROWS[r]) begin
            for (k = 0; k < 20; k++) begin
                bus(0, OFS_STAT, 0);
                if (q[7:0] < 8'hC8) break;
                repeat (40) @(posedge clk);
            end
            bus(1, OFS_UQB, 32'({ROWS[r].sel, 1'b0, ROWS[r].quad}));
            bus(1, OFS_COS, 32'(ROWS[r].cos_v));
            bus(1, OFS_SIN, 32'(ROWS[r].sin_v));
            t0 = cyc;
            bus(0, OFS_SIN, 0);
            chk("busy after sine", 32'h1, q);
            for (k = 0; k < 600; k++) begin
                bus(0, OFS_SIN, 0);
                if (q[0] === 1'b0) break;
            end
            if (k == 600) timeout("busy clear");
            chk("busy time", 32'h1,
                32'((cyc - t0) <= PERIOD_TICKS * DIV_FAST + 8));
            bus(0, OFS_COS, 0);
            chk("cosine read", 32'h0, q);
            repeat (64) @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            for (k = 0; k < 2000; k++) begin
                @(posedge clk);
                if (done === 1'b1) break;
            end
            if (k == 2000) timeout("meter");
            u = 2 * int'(ROWS[r].sel);
            chk("coil1 plus", 32'(ROWS[r].exp[31:24]) * DIV_FAST,
                32'(plus_cnt[u]));
            chk("coil1 minus", 32'(ROWS[r].exp[23:16]) * DIV_FAST,
                32'(minus_cnt[u]));
            chk("coil2 plus", 32'(ROWS[r].exp[15:8]) * DIV_FAST,
                32'(plus_cnt[u + 1]));
            chk("coil2 minus", 32'(ROWS[r].exp[7:0]) * DIV_FAST,
                32'(minus_cnt[u + 1]));
        end
        // a write with byte lane 0 off leaves the module enabled
        avs_byteenable <= 4'hE;
        bus(1, OFS_CTL, 32'h0);
        avs_byteenable <= 4'hF;
        bus(0, OFS_CTL, 0);
        chk("lane 0 off", 32'h1, q);
        bus(1, OFS_CTL, 32'h0);
        // unit clear and output register come before the legs fall
        repeat (2) @(posedge clk);
        quiet(4, "outputs after disable");
        bus(0, OFS_STAT, 0);
        chk("status after disable", 32'h0, q);
        bus(1, OFS_CTL, 32'h1);
        quiet(1400, "units cleared");
        // slow option: ten system clocks per ramp step
        hw_clk_sel <= 1'b1;
        repeat (20) @(posedge clk);
        bus(0, OFS_STAT, 0);
        s1 = q;
        repeat (97) @(posedge clk);
        bus(0, OFS_STAT, 0);
        chk("slow ramp", 32'(100 / DIV_SLOW),
            32'(8'(q[7:0] - s1[7:0])));
        results();
    end
endmodule
